// ---- rtl/pdm_pkg.sv ----
// device memory bank constants: word map, area classes, constant limits
// assumes one 25 MHz system clock; the word map is a scaled-down store
package pdm_pkg;
    localparam int AW = 8;
    localparam int DW = 16;
    localparam int IO_BITS = 64;
    localparam int IO_IDX_W = 6;
    // word map of the on-chip store (auxiliary, data, file words)
    localparam logic [AW-1:0] AUX_BASE  = 8'h00;
    localparam logic [AW-1:0] AUX_LAST  = 8'h1f;
    localparam logic [AW-1:0] DATA_BASE = 8'h20;
    localparam logic [AW-1:0] DATA_LAST = 8'h9f;
    localparam logic [AW-1:0] FILE_BASE = 8'ha0;
    localparam logic [AW-1:0] MEM_LAST  = 8'hff;
    localparam logic [AW-1:0] ADDR_ONE  = 8'h01;
    // default latched ranges, as word offsets inside each type
    localparam logic [AW-1:0] AUX_LAT_LO_DEF  = 8'h17;
    localparam logic [AW-1:0] AUX_LAT_HI_DEF  = 8'h1f;
    localparam logic [AW-1:0] DATA_LAT_LO_DEF = 8'h55;
    localparam logic [AW-1:0] DATA_LAT_HI_DEF = 8'h7f;
    // area classes, one bit each in a clear mask
    localparam int CLS_N = 4;
    localparam int CLS_Y = 0;
    localparam int CLS_NL = 1;
    localparam int CLS_FILE = 2;
    localparam int CLS_LAT = 3;
    localparam logic [CLS_N-1:0] MASK_NONE = 4'h0;
    localparam logic [CLS_N-1:0] MASK_Y    = 4'h1;
    localparam logic [CLS_N-1:0] MASK_NL   = 4'h2;
    localparam logic [CLS_N-1:0] MASK_FILE = 4'h4;
    localparam logic [CLS_N-1:0] MASK_LAT  = 4'h8;
    localparam logic [CLS_N-1:0] MASK_ALL  = 4'hf;
    localparam logic [DW-1:0] WORD_ZERO = 16'h0000;
    localparam logic [IO_BITS-1:0] IO_ZERO = 64'h0000_0000_0000_0000;
    // decimal constant limits
    localparam logic signed [31:0] K16_MIN = 32'shffff_8000;
    localparam logic signed [31:0] K16_MAX = 32'sh0000_7fff;
    localparam logic signed [31:0] K32_MIN = 32'sh8000_0000;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SWEEP = 2'b10
    } pdm_state_e;
endpackage

// ---- rtl/pdm_word_ram.sv ----
// single-port word store for the device memory
// assumes the owner never reads and writes the same cycle by accident
`timescale 1ns/1ps
module pdm_word_ram (
    // clock and reset
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_n_in,
    // access port
    input  wire logic                    we_in,
    input  wire logic [pdm_pkg::AW-1:0]  addr_in,
    input  wire logic [pdm_pkg::DW-1:0]  wdata_in,
    output logic      [pdm_pkg::DW-1:0]  rdata_out
);
    import pdm_pkg::*;
    // array has no reset: retained contents must survive a reset
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] next_rdata;

    always_comb begin
        next_rdata = mem[addr_in];
    end

    always_ff @(posedge sys_clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= WORD_ZERO;
        end else begin
            rdata_out <= next_rdata;
        end
    end
endmodule

// ---- rtl/pdm_device_memory.sv ----
// device memory bank: io images, word store, area clear sequencer
// assumes the scan engine runs on sys_clk_in; ext_in comes from pins
`timescale 1ns/1ps
// Operation
// RL1 - stop to run clears non-latched devices unless retained; latched kept
// RL2 - run to stop clears output relays by default unless retain chosen
// RL3 - with output retain selected, run to stop changes nothing
// RL4 - output clear on run to stop touches only output relays
// RL5 - non-latched clear flag on clears all non-latched devices only
// RL6 - latched clear flag on clears latched devices except file words
// RL7 - file words written only by dedicated instruction, word access only
// RL8 - decimal constants signed 16 bit -32768..32767, 32 bit to -2147483648
// RL9 - latched range is one contiguous range in its type; rest non-latched
// RL10 - inputs sampled into input image only at scan start
// RL11 - output image goes to terminals only after end instruction; a relay clear zeroes the terminals at once
// RL12 - power-up clears non-latched devices, keeps latched and file words
// RL13 - restore to defaults clears every device, file words included
module pdm_device_memory (
    // clock and reset
    input  wire logic                          sys_clk_in,
    input  wire logic                          rst_n_in,
    // scan engine control
    input  wire logic                          run_mode_in,
    input  wire logic                          scan_start_in,
    input  wire logic                          end_exec_in,
    input  wire logic                          restore_in,
    input  wire logic                          nonlatched_clear_flag_in,
    input  wire logic                          latched_clear_flag_in,
    // configuration
    input  wire logic                          nl_retain_in,
    input  wire logic                          y_retain_in,
    input  wire logic [pdm_pkg::AW-1:0]        aux_lat_lo_in,
    input  wire logic [pdm_pkg::AW-1:0]        aux_lat_hi_in,
    input  wire logic [pdm_pkg::AW-1:0]        data_lat_lo_in,
    input  wire logic [pdm_pkg::AW-1:0]        data_lat_hi_in,
    // word access from the program
    input  wire logic                          rd_en_in,
    input  wire logic                          wr_en_in,
    input  wire logic                          file_instr_in,
    input  wire logic [pdm_pkg::AW-1:0]        addr_in,
    input  wire logic [pdm_pkg::DW-1:0]        wr_data_in,
    output logic      [pdm_pkg::DW-1:0]        rd_data_out,
    output logic                               rd_valid_out,
    output logic                               wr_refused_out,
    // output relay bit writes
    input  wire logic                          y_wr_in,
    input  wire logic [pdm_pkg::IO_IDX_W-1:0]  y_idx_in,
    input  wire logic                          y_val_in,
    // pins and images
    input  wire logic [pdm_pkg::IO_BITS-1:0]   ext_in,
    output logic      [pdm_pkg::IO_BITS-1:0]   x_image_out,
    output logic      [pdm_pkg::IO_BITS-1:0]   out_term_out,
    // constant range check
    input  wire logic signed [31:0]            const_val_in,
    input  wire logic                          const_wide_in,
    output logic                               const_ok_out,
    // status
    output logic                               busy_out,
    output logic      [1:0]                    lat_range_ok_out
);
    import pdm_pkg::*;

    pdm_state_e          state, next_state;
    logic [AW-1:0]       sweep_addr, next_sweep_addr;
    logic [CLS_N-1:0]    pend, next_pend, act, next_act;
    logic                pwr_pend, next_pwr_pend;
    logic                run_q, next_run_q;
    logic [IO_BITS-1:0]  ext_s1, ext_s2;
    logic [IO_BITS-1:0]  x_img, next_x_img;
    logic [IO_BITS-1:0]  y_img, next_y_img;
    logic [IO_BITS-1:0]  term, next_term;
    logic                rd_v, next_rd_v;
    logic [CLS_N-1:0]    req;
    logic                start;
    logic                aux_ok, data_ok;
    logic                mem_we;
    logic [AW-1:0]       mem_addr;
    logic [DW-1:0]       mem_wdata;
    logic [CLS_N-1:0]    sweep_cls, prog_cls;
    logic                prog_wr_ok;

    // a range outside its type, or reversed, latches nothing
    assign aux_ok  = (aux_lat_lo_in <= aux_lat_hi_in)
                   && (aux_lat_hi_in <= (AUX_LAST - AUX_BASE));    // [RL9]
    assign data_ok = (data_lat_lo_in <= data_lat_hi_in)
                   && (data_lat_hi_in <= (DATA_LAST - DATA_BASE)); // [RL9]
    assign lat_range_ok_out = {data_ok, aux_ok};

    function automatic logic [CLS_N-1:0] cls_of(input logic [AW-1:0] a,
                                               input logic aok,
                                               input logic dok,
                                               input logic [AW-1:0] alo,
                                               input logic [AW-1:0] ahi,
                                               input logic [AW-1:0] dlo,
                                               input logic [AW-1:0] dhi);
        logic [AW-1:0] off;
        off = WORD_ZERO[AW-1:0];
        if (a >= FILE_BASE) begin
            cls_of = MASK_FILE;
        end else if (a >= DATA_BASE) begin
            off = a - DATA_BASE;
            cls_of = (dok && off >= dlo && off <= dhi) ? MASK_LAT
                                                       : MASK_NL;  // [RL9]
        end else begin
            off = a - AUX_BASE;
            cls_of = (aok && off >= alo && off <= ahi) ? MASK_LAT
                                                       : MASK_NL;  // [RL9]
        end
    endfunction

    assign sweep_cls = cls_of(sweep_addr, aux_ok, data_ok, aux_lat_lo_in,
                              aux_lat_hi_in, data_lat_lo_in, data_lat_hi_in);
    assign prog_cls  = cls_of(addr_in, aux_ok, data_ok, aux_lat_lo_in,
                              aux_lat_hi_in, data_lat_lo_in, data_lat_hi_in);

    // clear requests gathered into one class mask
    always_comb begin
        req = MASK_NONE;
        if (pwr_pend) begin
            req = req | MASK_Y | MASK_NL;                          // [RL12]
        end
        if (run_mode_in && !run_q && !nl_retain_in) begin
            req = req | MASK_Y | MASK_NL;                          // [RL1]
        end
        if (!run_mode_in && run_q && !y_retain_in) begin
            req = req | MASK_Y;  // [RL2] [RL3] [RL4]
        end
        if (nonlatched_clear_flag_in) begin
            req = req | MASK_Y | MASK_NL;                          // [RL5]
        end
        if (latched_clear_flag_in) begin
            req = req | MASK_LAT;                                  // [RL6]
        end
        if (restore_in) begin
            req = MASK_ALL;                                        // [RL13]
        end
    end

    assign start = (state == ST_IDLE) && (pend != MASK_NONE);

    // sequencer: one word per cycle through the whole store
    always_comb begin
        next_state      = state;
        next_sweep_addr = sweep_addr;
        next_act        = act;
        // a request in the taking cycle lands in pend again: set wins
        next_pend       = (start ? MASK_NONE : pend) | req;
        next_pwr_pend   = 1'b0;
        next_run_q      = run_mode_in;
        unique case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state      = ST_SWEEP;
                    next_act        = pend;
                    next_sweep_addr = AUX_BASE;
                end
            end
            ST_SWEEP: begin
                next_sweep_addr = sweep_addr + ADDR_ONE;
                if (sweep_addr == MEM_LAST) begin
                    next_state = ST_IDLE;
                    next_act   = MASK_NONE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state      <= ST_IDLE;
            sweep_addr <= AUX_BASE;
            act        <= MASK_NONE;
            pend       <= MASK_NONE;
            pwr_pend   <= 1'b1;
            run_q      <= 1'b0;
        end else begin
            state      <= next_state;
            sweep_addr <= next_sweep_addr;
            act        <= next_act;
            pend       <= next_pend;
            pwr_pend   <= next_pwr_pend;
            run_q      <= next_run_q;
        end
    end

    assign busy_out = (state == ST_SWEEP);

    // file words take a write only under the dedicated instruction
    assign prog_wr_ok = wr_en_in && !busy_out
                      && (prog_cls != MASK_FILE || file_instr_in); // [RL7]
    assign wr_refused_out = wr_en_in && !prog_wr_ok;
    assign mem_we    = busy_out ? ((sweep_cls & act) != MASK_NONE)
                                : prog_wr_ok;
    assign mem_addr  = busy_out ? sweep_addr : addr_in;
    assign mem_wdata = busy_out ? WORD_ZERO : wr_data_in;

    pdm_word_ram u_ram (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .we_in      (mem_we),
        .addr_in    (mem_addr),
        .wdata_in   (mem_wdata),
        .rdata_out  (rd_data_out)
    );

    // io images and read strobe
    always_comb begin
        next_x_img = x_img;
        next_y_img = y_img;
        next_term  = term;
        next_rd_v  = rd_en_in && !busy_out && !wr_en_in;
        if (scan_start_in) begin
            next_x_img = ext_s2;                                   // [RL10]
        end
        if (y_wr_in) begin
            next_y_img[y_idx_in] = y_val_in;
        end
        if (end_exec_in) begin
            next_term = y_img;                                     // [RL11]
        end
        // cleared relays also drop at the terminals, as no scan may follow
        if (start && pend[CLS_Y]) begin
            next_y_img = IO_ZERO;                                  // [RL2]
            next_term  = IO_ZERO;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_s1 <= IO_ZERO;
            ext_s2 <= IO_ZERO;
            x_img  <= IO_ZERO;
            y_img  <= IO_ZERO;
            term   <= IO_ZERO;
            rd_v   <= 1'b0;
        end else begin
            ext_s1 <= ext_in;
            ext_s2 <= ext_s1;
            x_img  <= next_x_img;
            y_img  <= next_y_img;
            term   <= next_term;
            rd_v   <= next_rd_v;
        end
    end

    assign x_image_out  = x_img;
    assign out_term_out = term;
    assign rd_valid_out = rd_v;

    assign const_ok_out = const_wide_in ? (const_val_in >= K32_MIN)
                        : (const_val_in >= K16_MIN
                           && const_val_in <= K16_MAX);            // [RL8]

    chk_file_write_guard: assert property (@(posedge sys_clk_in) // [RL7]
        disable iff (!rst_n_in)
        (mem_we && !busy_out && addr_in >= FILE_BASE) |-> file_instr_in)
        else $error("file word written without instruction");
    chk_sweep_file_kept: assert property (@(posedge sys_clk_in) // [RL5]
        disable iff (!rst_n_in)
        (busy_out && sweep_addr >= FILE_BASE && !act[CLS_FILE]) |-> !mem_we)
        else $error("file word cleared by non-latched clear");
    chk_restore_all: assert property (@(posedge sys_clk_in) // [RL13]
        disable iff (!rst_n_in)
        (restore_in && state == ST_IDLE && pend == MASK_NONE)
        |=> (pend == MASK_ALL) ##1 (busy_out && act == MASK_ALL))
        else $error("restore did not clear every class");
    chk_s2r_clear: assert property (@(posedge sys_clk_in) // [RL1]
        disable iff (!rst_n_in)
        (run_mode_in && !run_q && !nl_retain_in) |=> pend[CLS_NL] || busy_out)
        else $error("stop to run clear not requested");
    chk_r2s_retain: assert property (@(posedge sys_clk_in) // [RL3]
        disable iff (!rst_n_in)
        (!run_mode_in && run_q && y_retain_in && !restore_in && !pwr_pend
         && !nonlatched_clear_flag_in && !latched_clear_flag_in)
        |=> pend == ($past(start) ? MASK_NONE : $past(pend)))
        else $error("retain selected but clear requested");
    chk_lat_flag_mask: assert property (@(posedge sys_clk_in) // [RL6]
        disable iff (!rst_n_in)
        (busy_out && act == MASK_LAT) |-> (mem_we == (sweep_cls == MASK_LAT)))
        else $error("latched clear touched wrong words");
    chk_sweep_length: assert property (@(posedge sys_clk_in) // [RL12]
        disable iff (!rst_n_in)
        start |=> busy_out [*8] ##[1:260] !busy_out)
        else $error("sweep length wrong");
    chk_term_update: assert property (@(posedge sys_clk_in) // [RL11]
        disable iff (!rst_n_in)
        (!end_exec_in && !start) |=> $stable(out_term_out))
        else $error("terminals changed without end instruction");
    chk_input_hold: assert property (@(posedge sys_clk_in) // [RL10]
        disable iff (!rst_n_in)
        !scan_start_in |=> $stable(x_image_out))
        else $error("input image changed mid scan");
    chk_const_range: assert property (@(posedge sys_clk_in) // [RL8]
        disable iff (!rst_n_in)
        (!const_wide_in && const_val_in == K16_MAX + 32'sd1) |-> !const_ok_out)
        else $error("16 bit constant range wrong");
endmodule

// ---- test/pdm_scan_model.sv ----
// scan engine stand-in: output bit writes, scan start and end strobes
// assumes one caller at a time; strobes change just after clock edges
`timescale 1ns/1ps
module pdm_scan_model (
    // clock
    input  wire logic                         sys_clk_in,
    // scan strobes
    output logic                              scan_start_out,
    output logic                              end_exec_out,
    // output relay bit writes
    output logic                              y_wr_out,
    output logic      [pdm_pkg::IO_IDX_W-1:0] y_idx_out,
    output logic                              y_val_out
);
    import pdm_pkg::*;
    initial begin
        scan_start_out = 1'b0;
        end_exec_out = 1'b0;
        y_wr_out = 1'b0;
        y_idx_out = '0;
        y_val_out = 1'b0;
    end
    // coil writes land one bit a cycle, as the program would make them
    task automatic put_y(input logic [IO_BITS-1:0] pat);
        for (int i = 0; i < IO_BITS; i++) begin
            @(posedge sys_clk_in);
            y_wr_out <= 1'b1;
            y_idx_out <= i[IO_IDX_W-1:0];
            y_val_out <= pat[i];
        end
        @(posedge sys_clk_in);
        y_wr_out <= 1'b0;
        // released lines must not keep showing the last bit
        y_idx_out <= ~y_idx_out;
        y_val_out <= ~y_val_out;
    endtask
    // input refresh opens the scan
    task automatic start_scan();
        @(posedge sys_clk_in);
        scan_start_out <= 1'b1;
        @(posedge sys_clk_in);
        scan_start_out <= 1'b0;
    endtask
    // end instruction closes it; a spare edge lets terminals land
    task automatic end_scan();
        @(posedge sys_clk_in);
        end_exec_out <= 1'b1;
        @(posedge sys_clk_in);
        end_exec_out <= 1'b0;
        @(posedge sys_clk_in);
    endtask
endmodule

// ---- test/plc_device_memory_retention_test.sv ----
// self-checking bench for the device memory bank, random and corner cases
// assumes pdm_pkg and pdm_scan_model are compiled before this file
`timescale 1ns/1ps
module plc_device_memory_retention_test;
    import pdm_pkg::*;
    logic               clk, rst_n, run, restore, nl_flag, lat_flag;
    logic               nl_ret, y_ret, rd_en, wr_en, fi, rvalid, refused;
    logic               scan_st, end_ex, y_wr, y_val, kwide, k_ok_o, busy;
    logic [AW-1:0]      alo, ahi, dlo, dhi, addr;
    logic [DW-1:0]      wdata, rdata;
    logic [IO_IDX_W-1:0] y_idx;
    logic [IO_BITS-1:0] ext, x_img, term, y_m, term_m;
    logic signed [31:0] kval;
    logic [1:0]         lat_ok;
    logic [DW-1:0]      mem_m [256];
    logic signed [31:0] kv [6] = '{-32768, 32767, 32768, -32769,
                                   32'sh8000_0000, 32'sh7fff_ffff};
    int                 err_total, check_count, n;

    pdm_device_memory i_dut (
        .sys_clk_in(clk), .rst_n_in(rst_n), .run_mode_in(run),
        .scan_start_in(scan_st), .end_exec_in(end_ex),
        .restore_in(restore), .nonlatched_clear_flag_in(nl_flag),
        .latched_clear_flag_in(lat_flag), .nl_retain_in(nl_ret),
        .y_retain_in(y_ret), .aux_lat_lo_in(alo), .aux_lat_hi_in(ahi),
        .data_lat_lo_in(dlo), .data_lat_hi_in(dhi), .rd_en_in(rd_en),
        .wr_en_in(wr_en), .file_instr_in(fi), .addr_in(addr),
        .wr_data_in(wdata), .rd_data_out(rdata), .rd_valid_out(rvalid),
        .wr_refused_out(refused), .y_wr_in(y_wr), .y_idx_in(y_idx),
        .y_val_in(y_val), .ext_in(ext), .x_image_out(x_img),
        .out_term_out(term), .const_val_in(kval), .const_wide_in(kwide),
        .const_ok_out(k_ok_o), .busy_out(busy), .lat_range_ok_out(lat_ok));
    pdm_scan_model i_scan (
        .sys_clk_in(clk), .scan_start_out(scan_st), .end_exec_out(end_ex),
        .y_wr_out(y_wr), .y_idx_out(y_idx), .y_val_out(y_val));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic rng_ok(input logic [AW-1:0] lo, hi, top);
        return lo <= hi && hi <= top;
    endfunction

    // reversed or oversize range leaves the whole type non-latched
    function automatic logic is_lat(input logic [AW-1:0] a);
        logic aux;
        logic [AW-1:0] lo, hi, off;
        aux = a < DATA_BASE;
        lo = aux ? alo : dlo;
        hi = aux ? ahi : dhi;
        off = a - (aux ? AUX_BASE : DATA_BASE);
        if (a >= FILE_BASE) return 1'b0;
        return rng_ok(lo, hi, aux ? 8'h1f : 8'h7f) && off >= lo && off <= hi;
    endfunction

    task automatic apply(input logic [CLS_N-1:0] m);
        logic [CLS_N-1:0] c;
        for (int a = 0; a < 256; a++) begin
            c = is_lat(8'(a)) ? MASK_LAT : MASK_NL;
            if (a >= FILE_BASE) c = MASK_FILE;
            if ((c & m) != MASK_NONE) mem_m[a] = WORD_ZERO;
        end
        if (m[CLS_Y]) y_m = IO_ZERO;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d,
                      input logic f, input logic ref_exp);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        fi <= f;
        @(negedge clk);
        check("wr_refused", refused, ref_exp);
        @(posedge clk);
        wr_en <= 1'b0;
        if (!ref_exp) mem_m[a] = d;
    endtask

    task automatic idle(output int k);
        for (k = 0; k < 300 && busy !== 1'b0; k++) @(negedge clk);
    endtask

    task automatic settle(input logic exp_sw);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 8 && !seen; i++) begin
            @(negedge clk);
            seen = busy;
        end
        check("sweep", seen, exp_sw);
        idle(n);
        check("busy", busy, 1'b0);
        if (exp_sw) check("sweep_len", n, 256);
    endtask

    task automatic show_term();
        i_scan.end_scan();
        term_m = y_m;
        @(negedge clk);
        check("out_term", term, term_m);
    endtask

    task automatic round(input int ev, input logic ret);
        logic [CLS_N-1:0] m;
        @(posedge clk);
        alo <= 8'($urandom_range(31));
        ahi <= 8'($urandom_range(31));
        dlo <= 8'($urandom_range(127));
        dhi <= (ev == 2) ? 8'h80 : 8'($urandom_range(127));
        nl_ret <= ret;
        y_ret <= ret;
        for (int a = 0; a < 256; a++) begin
            wr(8'(a), 16'($urandom), 1'b1, 1'b0);
        end
        wr(FILE_BASE + 8'($urandom_range(95)), 16'hffff, 1'b0, 1'b1);
        check("lat_ok", lat_ok, {rng_ok(dlo, dhi, 8'h7f),
                                 rng_ok(alo, ahi, 8'h1f)});
        y_m = {$urandom, $urandom};
        i_scan.put_y(y_m);
        @(negedge clk);
        check("out_term_hold", term, term_m);
        show_term();
        @(posedge clk);
        case (ev)
            0, 1: run <= ~run;
            2: nl_flag <= 1'b1;
            3: lat_flag <= 1'b1;
            4: restore <= 1'b1;
            default: rst_n <= 1'b0;
        endcase
        @(posedge clk);
        nl_flag <= 1'b0;
        lat_flag <= 1'b0;
        restore <= 1'b0;
        if (ev == 5) begin
            @(negedge clk);
            check("term_in_reset", term, IO_ZERO);
            @(posedge clk);
            rst_n <= 1'b1;
        end
        case (ev)
            0: m = ret ? MASK_NONE : MASK_Y | MASK_NL;
            1: m = ret ? MASK_NONE : MASK_Y;
            2, 5: m = MASK_Y | MASK_NL;
            3: m = MASK_LAT;
            default: m = MASK_ALL;
        endcase
        settle(m != MASK_NONE);
        apply(m);
        for (int a = 0; a < 256; a++) begin
            @(posedge clk);
            rd_en <= 1'b1;
            addr <= 8'(a);
            @(posedge clk);
            rd_en <= 1'b0;
            @(negedge clk);
            check("rd_valid", rvalid, 1'b1);
            check("word", rdata, mem_m[a]);
        end
        show_term();
    endtask

    task automatic scan_in();
        logic [IO_BITS-1:0] v;
        v = {$urandom, $urandom};
        @(posedge clk);
        ext <= v;
        repeat (4) @(posedge clk);
        i_scan.start_scan();
        repeat (3) @(posedge clk);
        ext <= ~v;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check("x_image", x_img, v);
    endtask

    task automatic consts();
        logic signed [31:0] v;
        logic e;
        for (int i = 0; i < 16; i++) begin
            v = (i < 12) ? kv[i / 2] : $urandom;
            e = i[0] || (v >= -32768 && v <= 32767);
            @(posedge clk);
            kval <= v;
            kwide <= i[0];
            @(negedge clk);
            check("const_ok", k_ok_o, e);
        end
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        {run, restore, nl_flag, lat_flag, nl_ret, y_ret} = '0;
        {rd_en, wr_en, fi, kwide} = '0;
        {alo, ahi, dlo, dhi, addr} = '0;
        wdata = '0;
        ext = '0;
        kval = '0;
        term_m = IO_ZERO;
        err_total = 0;
        check_count = 0;
        void'($urandom(90660));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // power-up sweep is running: the store must refuse this write
        wr(8'h10, 16'h1234, 1'b1, 1'b1);
        idle(n);
        consts();
        repeat (3) scan_in();
        round(0, 1'b0);
        round(1, 1'b0);
        round(0, 1'b1);
        round(1, 1'b1);
        for (int e = 2; e < 6; e++) round(e, 1'b0);
        close_out();
    end
endmodule
